// ---- hdl/emrx_top.sv ----
// emrx_top: receive half of an ethernet mac, line to byte stream plus frame status
// ============================================================================
// Operation
// - activity is srl enable, mii valid and carrier, or symbol-port activity.
// - mii/symbol mode accepts any preamble of at least 8 bits.
// - serial mode needs 16 bits of preamble and delimiter before the closing 1, so at least 9 preamble bits.
// - snooze needs at least 20 preamble bits in mii/symbol mode, 13 in serial mode.
// - start delimiter 10101011 ends preamble; serial first skips 8 bits.
// - serial: 00 after the first 8 bits, or early 11, aborts; mii/symbol: nibble 0, C or 3, or an early delimiter, aborts; then wait for line idle.
// - symbol mode frame must begin with J K, else abort until idle.
// - first destination bit 0 is physical, 1 is multicast.
// - address match delivers frame; mismatch stops after the first 7 bytes are sent, and raises no done.
// - accept-all bit 30 takes every frame, filter fail in status bit 30.
// - crc checked every frame; symbol mode also needs closing T R.
// - fifo overflow ends frame and sets status bit 0.
// - watchdog expiry cuts frame, sets interrupt bit 9, status bit 4.
// - collision after 64 bytes completes frame, sets status bit 6.
// - mii error, bad symbol or missing T R also flags crc error.
// - dribble flagged at 4 bits mii/symbol, 3 or more serial; whole bytes crc.
// - alignment error is crc error together with dribble error.
// - under 64 bytes is runt; rejected unless runt acceptance set.
// - over 1500 bytes sets too-long error; never reached, as the watchdog cuts every frame at 2048 link periods.
// - at end write status word and raise done status.
// - loopback at 10 Mb/s, or at port rate with mii/symbol enabled.
// - bits 11:10 pick loopback; internal loopback ignores the medium.
`timescale 1ns/1ns
module emrx_top (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rstn,
  input  wire emrx_pkg::emrx_bus_t  i_bus,
  output logic [31:0]               o_rdata,
  input  wire logic                 i_line_clk,
  input  wire emrx_pkg::emrx_line_t i_line,
  input  wire emrx_pkg::emrx_line_t i_loop,
  input  wire logic                 i_addr_match,
  input  wire logic                 i_fifo_ready,
  output emrx_pkg::emrx_byte_t      o_byte,
  output logic                      o_frame_done,
  output logic                      o_medium_off
);

  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_JK = 6'h02, S_PRE = 6'h04,
    S_DATA = 6'h08, S_WAIT = 6'h10, S_DONE = 6'h20
  } emrx_st_t;

  typedef struct packed {
    emrx_st_t               st;
    logic [31:0]            opm;
    logic [31:0]            isr;
    logic [31:0]            rstat;
    logic [31:0]            rdata;
    logic [10:0]            len;
    logic [4:0]             pre;
    logic [1:0]             last2;
    logic [7:0]             sh;
    logic [2:0]             nb;
    logic [31:0]            crc;
    logic [15:0]            wdog;
    logic                   jk_j;
    logic                   tr_t;
    logic                   tr_ok;
    logic                   errf;
    logic                   ovf;
    logic                   coll;
    logic                   fail;
    logic                   multi;
    logic                   lclk_d;
    emrx_pkg::emrx_byte_t   ob;
    logic                   done;
  } emrx_state_t;

  emrx_state_t q, d;
  emrx_pkg::emrx_line_t ln_s1_q, ln_s2_q;
  logic lck_s1_q, lck_s2_q;

  // ==========================================================================
  // crc step over one bit, lsb first
  function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic b);
    crc_bit = (c[0] ^ b) ? ((c >> 1) ^ emrx_pkg::CRC_POLY) : (c >> 1);
  endfunction

  // ==========================================================================
  // line synchronisers; loopback mux sits before them
  emrx_pkg::emrx_line_t ln_src;
  always_comb begin
    ln_src = i_line;
    if (q.opm[emrx_pkg::OPM_LOOP_HI:emrx_pkg::OPM_LOOP_LO] == emrx_pkg::LOOP_INT) begin
      ln_src = i_loop;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      ln_s1_q  <= '0;
      ln_s2_q  <= '0;
      lck_s1_q <= 1'b0;
      lck_s2_q <= 1'b0;
    end else begin
      ln_s1_q  <= ln_src;
      ln_s2_q  <= ln_s1_q;
      lck_s1_q <= i_line_clk;
      lck_s2_q <= lck_s1_q;
    end
  end

  // ==========================================================================
  // receive machine; one step per rising link clock edge
  logic [1:0]  mode;
  logic        act;
  logic        edge_en;
  logic [2:0]  nbits;
  logic [3:0]  bits;
  logic [4:0]  need;
  logic        bad_sym;
  logic [1:0]  pair;
  logic        crc_bad;
  logic        drib;
  logic        runt;

  always_comb begin
    d       = q;
    d.done  = 1'b0;
    d.ob.valid = 1'b0;
    d.ob.last  = 1'b0;
    d.lclk_d   = lck_s2_q;
    mode    = q.opm[emrx_pkg::OPM_PORTSEL +: 2];
    // loopback runs symbol-port mode as mii; serial and mii keep their mode
    if (q.opm[emrx_pkg::OPM_LOOP_HI:emrx_pkg::OPM_LOOP_LO] != emrx_pkg::LOOP_NONE
        && mode == emrx_pkg::MODE_SYM) begin
      mode = emrx_pkg::MODE_MII;
    end
    edge_en = lck_s2_q & ~q.lclk_d;
    case (mode)
      emrx_pkg::MODE_MII: act = ln_s2_q.dv & ln_s2_q.mii_crs;
      emrx_pkg::MODE_SYM: act = ln_s2_q.sym_act;
      default:            act = ln_s2_q.srl_rxen;
    endcase
    act = act & q.opm[emrx_pkg::OPM_RXEN];
    nbits   = (mode == emrx_pkg::MODE_SRL) ? 3'h1 : 3'h4;
    bits    = (mode == emrx_pkg::MODE_SRL) ? {3'h0, ln_s2_q.srl_data} : ln_s2_q.mii_d;
    bad_sym = (mode == emrx_pkg::MODE_SYM) && (ln_s2_q.sym == 5'h00);
    need    = q.opm[emrx_pkg::OPM_SNOOZE] ? emrx_pkg::PRE_SNOOZE :
              (mode == emrx_pkg::MODE_SRL) ? emrx_pkg::PRE_SRL :
              emrx_pkg::PRE_MII;
    pair    = 2'h0;
    crc_bad = 1'b0;
    drib    = 1'b0;
    runt    = 1'b0;

    if (edge_en) begin
      case (q.st)
        S_IDLE: begin
          d.pre = 5'h00;
          d.last2 = 2'h0;
          d.len = 11'h000;
          d.nb = 3'h0;
          d.crc = emrx_pkg::CRC_INIT;
          d.wdog = 16'h0000;
          {d.errf, d.ovf, d.coll, d.fail, d.multi, d.tr_t, d.tr_ok, d.jk_j} = '0;
          if (act) begin
            if (mode == emrx_pkg::MODE_SYM) begin
              d.st = S_JK;
              d.jk_j = (ln_s2_q.sym == emrx_pkg::SYM_J);
            end else begin
              d.st = S_PRE;
              d.pre = (mode == emrx_pkg::MODE_SRL) ? 5'h01 : 5'h04;
              d.last2 = {1'b0, bits[0]};
            end
          end
        end
        S_JK: begin
          if (!act) begin
            d.st = S_IDLE;
          end else if (q.jk_j && ln_s2_q.sym == emrx_pkg::SYM_K) begin
            d.st = S_PRE;
          end else begin
            d.st = S_WAIT;
          end
        end
        S_PRE: begin
          if (!act) begin
            d.st = S_IDLE;
          end else if (mode == emrx_pkg::MODE_SRL) begin
            d.pre = (q.pre == 5'h1F) ? q.pre : q.pre + 5'h01;
            pair  = {q.last2[0], bits[0]};
            d.last2 = pair;
            if (q.pre >= emrx_pkg::SRL_SKIP) begin
              if (pair == 2'h0) begin
                d.st = S_WAIT;
              end else if (pair == 2'h3) begin
                if (q.pre < emrx_pkg::ELEVEN_SRL || q.pre < need) begin
                  d.st = S_WAIT;
                end else begin
                  d.st = S_DATA;
                end
              end
            end
          end else begin
            d.pre = (q.pre >= 5'h1B) ? q.pre : q.pre + 5'h04;
            if (bits == 4'h0 || bits == 4'hC || bits == 4'h3) begin
              d.st = S_WAIT;
            end else if (bits == emrx_pkg::SFD_BYTE[7:4]) begin
              // q.pre still holds the delimiter's low nibble, so it is not preamble
              if (q.pre < emrx_pkg::ELEVEN_MII || q.pre < need + 5'h04) begin
                d.st = S_WAIT;
              end else begin
                d.st = S_DATA;
              end
            end
          end
        end
        S_DATA: begin
          d.wdog = q.wdog + 16'h0001;
          if (ln_s2_q.coll && q.len >= emrx_pkg::MIN_LEN) begin
            d.coll = 1'b1;
          end
          if (mode == emrx_pkg::MODE_MII && ln_s2_q.mii_err) begin
            d.errf = 1'b1;
          end
          if (act && mode == emrx_pkg::MODE_SYM) begin
            d.tr_t = (ln_s2_q.sym == emrx_pkg::SYM_T);
            if (q.tr_t && ln_s2_q.sym == emrx_pkg::SYM_R) begin
              d.tr_ok = 1'b1;
            end else if (bad_sym) begin
              d.errf = 1'b1;
            end
          end
          if (act && !q.tr_t && !d.tr_t) begin
            d.sh = (nbits == 3'h1) ? {bits[0], q.sh[7:1]} : {bits, q.sh[7:4]};
            d.nb = q.nb + nbits;
            if (d.nb == 3'h0) begin
              // whole byte: crc, length and deliver
              d.crc = q.crc;
              for (int i = 0; i < 8; i++) begin
                d.crc = crc_bit(d.crc, d.sh[i]);
              end
              d.len = (q.len == 11'h7FF) ? q.len : q.len + 11'h001;
              if (q.len == 11'h000) begin
                d.multi = d.sh[0];
              end
              if (q.len == 11'h006) begin
                d.fail = ~i_addr_match;
              end
              if (!i_fifo_ready) begin
                d.ovf = 1'b1;
              end
              d.ob.data  = d.sh;
              d.ob.valid = ~q.fail | q.opm[emrx_pkg::OPM_ALL];
            end
          end
          if (q.fail && !q.opm[emrx_pkg::OPM_ALL]) begin
            d.st = S_WAIT;
          end else if (!act || d.ovf
                       || q.wdog == 16'(emrx_pkg::WDOG_BITS - 1)) begin
            if (q.wdog == 16'(emrx_pkg::WDOG_BITS - 1) && act) begin
              d.isr[emrx_pkg::IS_RXWDG] = 1'b1;
              d.rstat[emrx_pkg::RS_WDOG] = 1'b1;
            end
            d.st = S_DONE;
          end
        end
        S_DONE: begin
          crc_bad = (q.crc != emrx_pkg::CRC_GOOD) | q.errf
                    | (mode == emrx_pkg::MODE_SYM && !q.tr_ok);
          drib = (mode == emrx_pkg::MODE_SRL) ? (q.nb >= 3'h3)
                                               : (q.nb == 3'h4);
          runt = q.len < emrx_pkg::MIN_LEN;
          d.rstat[emrx_pkg::RS_OVF]   = q.ovf;
          d.rstat[emrx_pkg::RS_CRC]   = crc_bad;
          d.rstat[emrx_pkg::RS_DRIB]  = drib;
          d.rstat[emrx_pkg::RS_ALIGN] = crc_bad & drib;
          d.rstat[emrx_pkg::RS_RUNT]  = runt;
          d.rstat[emrx_pkg::RS_LONG]  = q.len > emrx_pkg::MAX_LEN;
          d.rstat[emrx_pkg::RS_COLL]  = q.coll;
          d.rstat[emrx_pkg::RS_MULTI] = q.multi;
          d.rstat[emrx_pkg::RS_FFAIL] = q.fail;
          d.rstat[emrx_pkg::RS_WDOG]  = (q.wdog == 16'(emrx_pkg::WDOG_BITS));
          d.rstat[emrx_pkg::RS_DESC]  = 1'b0;
          d.rstat[emrx_pkg::RS_OWN]   = 1'b0;
          d.rstat[26:16] = q.len;
          if (!runt || q.opm[emrx_pkg::OPM_RUNTOK]) begin
            d.ob.valid = 1'b1;
            d.ob.last  = 1'b1;
            d.ob.data  = 8'h00;
            d.isr[emrx_pkg::IS_RXDONE] = 1'b1;
            d.done = 1'b1;
          end
          d.st = act ? S_WAIT : S_IDLE;
        end
        S_WAIT: begin
          if (!act) begin
            d.st = S_IDLE;
          end
        end
        default: d.st = S_IDLE;
      endcase
    end

    // register access; hardware set of a clear bit wins over software clear
    d.rdata = 32'h0000_0000;
    if (i_bus.wr) begin
      case (i_bus.addr)
        emrx_pkg::OFS_OPMODE:  d.opm = i_bus.wdata;
        emrx_pkg::OFS_INTSTAT: d.isr = (q.isr & ~i_bus.wdata) | (d.isr & ~q.isr);
        default: ;
      endcase
    end
    if (i_bus.rd) begin
      case (i_bus.addr)
        emrx_pkg::OFS_OPMODE:  d.rdata = q.opm;
        emrx_pkg::OFS_INTSTAT: d.rdata = q.isr;
        emrx_pkg::OFS_RXSTAT:  d.rdata = q.rstat;
        emrx_pkg::OFS_RXLEN:   d.rdata = {21'h0, q.len};
        default:               d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      q       <= '0;
      q.st    <= S_IDLE;
      q.opm   <= emrx_pkg::OPM_RESET;
      q.crc   <= emrx_pkg::CRC_INIT;
    end else begin
      q <= d;
    end
  end

  assign o_rdata      = q.rdata;
  assign o_byte       = q.ob;
  assign o_frame_done = q.done;
  assign o_medium_off = (q.opm[emrx_pkg::OPM_LOOP_HI:emrx_pkg::OPM_LOOP_LO]
                         == emrx_pkg::LOOP_INT);

endmodule

// ---- hdl/emrx_pkg.sv ----
// emrx_pkg: constants, offsets, field layouts and carrier types for the receive path
package emrx_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_OPMODE   = 8'h00;
  localparam logic [7:0] OFS_INTSTAT  = 8'h04;
  localparam logic [7:0] OFS_RXSTAT   = 8'h08;
  localparam logic [7:0] OFS_RXLEN    = 8'h0C;

  // ==========================================================================
  // operating-mode fields
  localparam int OPM_RXEN     = 1;
  localparam int OPM_PORTSEL  = 2;   // 2 bits: mode
  localparam int OPM_SNOOZE   = 4;
  localparam int OPM_RUNTOK   = 5;
  localparam int OPM_LOOP_LO  = 10;
  localparam int OPM_LOOP_HI  = 11;
  localparam int OPM_ALL      = 30;
  localparam logic [31:0] OPM_RESET = 32'h0000_0000;

  localparam logic [1:0] MODE_SRL = 2'h0;
  localparam logic [1:0] MODE_MII = 2'h1;
  localparam logic [1:0] MODE_SYM = 2'h2;

  localparam logic [1:0] LOOP_NONE = 2'h0;
  localparam logic [1:0] LOOP_INT  = 2'h1;
  localparam logic [1:0] LOOP_EXT  = 2'h2;

  // ==========================================================================
  // status word fields and interrupt status
  localparam int RS_OVF   = 0;
  localparam int RS_CRC   = 1;
  localparam int RS_DRIB  = 2;
  localparam int RS_WDOG  = 4;
  localparam int RS_COLL  = 6;
  localparam int RS_LONG  = 7;
  localparam int RS_ALIGN = 8;
  localparam int RS_RUNT  = 11;
  localparam int RS_DESC  = 14;
  localparam int RS_MULTI = 10;
  localparam int RS_FFAIL = 30;
  localparam int RS_OWN   = 31;
  localparam int IS_RXWDG = 9;
  localparam int IS_RXDONE = 6;

  // ==========================================================================
  // counts
  localparam logic [4:0]  PRE_MII    = 5'h08;
  localparam logic [4:0]  PRE_SRL    = 5'h10;
  localparam logic [4:0]  PRE_SNOOZE = 5'h14;
  localparam logic [4:0]  SRL_SKIP   = 5'h08;
  localparam logic [4:0]  ELEVEN_SRL = 5'h0E;
  localparam logic [4:0]  ELEVEN_MII = 5'h06;
  localparam logic [7:0]  SFD_BYTE   = 8'hD5;  // 10101011 in line order, lsb first
  localparam logic [10:0] MIN_LEN    = 11'h040;
  localparam logic [10:0] MAX_LEN    = 11'h5DC;
  localparam logic [31:0] CRC_INIT   = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY   = 32'hEDB8_8320;
  localparam logic [31:0] CRC_GOOD   = 32'hDEBB_20E3;
  localparam int          WDOG_BITS  = 2048;

  // 5-bit code groups of the symbol port
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } emrx_bus_t;

  typedef struct packed {
    logic       srl_rxen;
    logic       srl_data;
    logic       mii_crs;
    logic       dv;
    logic       mii_err;
    logic [3:0] mii_d;
    logic       sym_act;
    logic [4:0] sym;
    logic       coll;
  } emrx_line_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       last;
  } emrx_byte_t;

endpackage

// ---- dv/emrx_top_monitor.sv ----
// emrx_top_monitor: concurrent checks on the receive path ports
`timescale 1ns/1ns
module emrx_top_monitor (
  input wire logic                 i_core_clk,
  input wire logic                 i_rstn,
  input wire emrx_pkg::emrx_bus_t  i_bus,
  input wire logic [31:0]          o_rdata,
  input wire logic                 i_line_clk,
  input wire emrx_pkg::emrx_line_t i_line,
  input wire emrx_pkg::emrx_line_t i_loop,
  input wire logic                 i_addr_match,
  input wire logic                 i_fifo_ready,
  input wire emrx_pkg::emrx_byte_t o_byte,
  input wire logic                 o_frame_done,
  input wire logic                 o_medium_off
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================================
  // shadow of operating mode, and cycles spent with reception off
  typedef struct packed {
    logic [31:0] opm;
    logic [7:0]  off;
  } emrx_mon_t;
  emrx_mon_t mon_q;
  emrx_mon_t mon_d;
  always_comb begin
    mon_d = mon_q;
    if (i_bus.wr && i_bus.addr == emrx_pkg::OFS_OPMODE) mon_d.opm = i_bus.wdata;
    if (mon_q.opm[emrx_pkg::OPM_RXEN]) mon_d.off = 8'h00;
    else if (mon_q.off != 8'hFF) mon_d.off = mon_q.off + 8'h01;
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) mon_q <= '{opm: emrx_pkg::OPM_RESET, off: 8'h00};
    else mon_q <= mon_d;
  end
  // ==========================================================================
  // properties
  sequence s_opm_read;
    i_bus.rd && i_bus.addr == emrx_pkg::OFS_OPMODE;
  endsequence
  sequence s_opm_write;
    i_bus.wr && i_bus.addr == emrx_pkg::OFS_OPMODE;
  endsequence
  a_opm_readback:
    assert property (s_opm_read |=> o_rdata[30] == $past(mon_q.opm[30])
      && o_rdata[11:10] == $past(mon_q.opm[11:10]) && o_rdata[5:1] == $past(mon_q.opm[5:1]))
    else $error("operating mode read back differs");
  a_rdata_idle:
    assert property (!i_bus.rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_rdata_unmapped:
    assert property (i_bus.rd && !(i_bus.addr inside {8'h00, 8'h04, 8'h08, 8'h0C})
      |=> o_rdata == 32'h0) else $error("unmapped read not zero");
  a_loop_medium:
    assert property (s_opm_write |-> ##2
      (o_medium_off == ($past(i_bus.wdata[11:10], 2) == emrx_pkg::LOOP_INT)))
    else $error("medium disconnect does not follow loopback field");
  a_done_pulse:
    assert property (o_frame_done |=> !o_frame_done [*8])
    else $error("frame done longer than one pulse");
  a_byte_pulse:
    assert property (o_byte.valid |=> !o_byte.valid [*3])
    else $error("byte strobe too long or too close");
  a_last_pulse:
    assert property ($rose(o_byte.last) |=> !o_byte.last)
    else $error("last marker longer than one pulse");
  a_idle_quiet:
    assert property (mon_q.off == 8'hFF |-> !o_byte.valid && !o_frame_done)
    else $error("traffic with reception disabled");
endmodule
bind emrx_top emrx_top_monitor emrx_top_monitor_inst (
  .i_core_clk, .i_rstn, .i_bus, .o_rdata, .i_line_clk, .i_line,
  .i_loop, .i_addr_match, .i_fifo_ready, .o_byte, .o_frame_done, .o_medium_off
);

// ---- dv/emrx_phy_model.sv ----
// emrx_phy_model: mii nibble transmitter standing in for the phy
`timescale 1ns/1ns
module emrx_phy_model (
  output logic                 o_line_clk,
  output emrx_pkg::emrx_line_t o_line
);
  int drib    = 0;
  int err_at  = -1;
  int coll_at = -1;
  initial begin
    o_line_clk = 1'b0;
    o_line     = '0;
  end
  // one link period; a released data line shows the inverse of its last nibble
  task automatic tick(input logic [3:0] d, input logic act, input int n);
    o_line.dv      = act;
    o_line.mii_crs = act;
    o_line.mii_d   = act ? d : ~o_line.mii_d;
    o_line.mii_err = act && (n == err_at);
    o_line.coll    = act && (coll_at >= 0) && (n >= coll_at) && (n < coll_at + 4);
    #400 o_line_clk = 1'b1;
    #400 o_line_clk = 1'b0;
  endtask
  // preamble, delimiter, bytes low nibble first, then a short idle tail
  task automatic send(input logic [7:0] b[$], input int pre, input logic [3:0] pn);
    for (int i = 0; i < pre; i++) tick(pn, 1'b1, -9);
    tick(4'h5, 1'b1, -9);
    tick(4'hD, 1'b1, -9);
    for (int i = 0; i < 2 * b.size(); i++) tick(i[0] ? b[i/2][7:4] : b[i/2][3:0], 1'b1, i);
    if (drib != 0) tick(4'h6, 1'b1, -9);
    for (int i = 0; i < 4; i++) tick(4'h0, 1'b0, -9);
  endtask
endmodule

// ---- dv/emrx_top_bench.sv ----
// emrx_top_bench: directed scenarios for the receive path
`timescale 1ns/1ns
module emrx_top_bench;
  logic                 clk      = 1'b0;
  logic                 rstn     = 1'b0;
  emrx_pkg::emrx_bus_t  bus      = '0;
  emrx_pkg::emrx_line_t pline;
  emrx_pkg::emrx_line_t idle     = '0;
  emrx_pkg::emrx_byte_t obyte;
  logic [31:0]          rdata;
  logic [31:0]          st;
  logic [31:0]          d;
  logic                 lclk;
  logic                 match    = 1'b1;
  logic                 fifo_rdy = 1'b1;
  logic                 use_loop = 1'b0;
  logic                 mcast    = 1'b0;
  logic                 done;
  logic                 moff;
  logic                 got;
  logic [7:0]           first_b;
  int                   failures = 0;
  int                   total_checks = 0;
  int                   ndone = 0;
  int                   base;
  always #50 clk = ~clk;
  emrx_phy_model emrx_phy_model_inst (.o_line_clk(lclk), .o_line(pline));
  emrx_top emrx_top_inst (
    .i_core_clk(clk), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata), .i_line_clk(lclk),
    .i_line(use_loop ? idle : pline), .i_loop(use_loop ? pline : idle),
    .i_addr_match(match), .i_fifo_ready(fifo_rdy), .o_byte(obyte),
    .o_frame_done(done), .o_medium_off(moff)
  );
  always @(posedge clk) begin
    if (done === 1'b1) ndone++;
    if (obyte.valid === 1'b1 && !got) begin
      first_b = obyte.data;
      got = 1'b1;
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // frame of len bytes including fcs; flip corrupts the fcs
  task automatic run(input int len, input int pre, input logic [3:0] pn, input logic [31:0] flip);
    logic [7:0]  q[$];
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < len - 4; i++) q.push_back(i == 0 ? {7'h00, mcast} : 8'(i * 7));
    foreach (q[i])
      for (int k = 0; k < 8; k++)
        c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? emrx_pkg::CRC_POLY : 32'h0);
    c = ~c ^ flip;
    for (int i = 0; i < 4; i++) q.push_back(c[8*i +: 8]);
    base = ndone;
    got = 1'b0;
    emrx_phy_model_inst.send(q, pre, pn);
    for (int k = 0; k < 50 && ndone == base; k++) @(posedge clk);
    rd(emrx_pkg::OFS_RXSTAT, st);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    rd(emrx_pkg::OFS_OPMODE, d);
    chk(d, emrx_pkg::OPM_RESET, "opmode reset");
    rd(8'h40, d);
    chk(d, 32'h0, "unmapped read");
    wr(emrx_pkg::OFS_OPMODE, 32'h4000_0426);
    rd(emrx_pkg::OFS_OPMODE, d);
    chk(d & 32'h4000_0C3E, 32'h4000_0426, "opmode readback");
    chk({31'h0, moff}, 32'h1, "internal loop keeps medium");
    wr(emrx_pkg::OFS_OPMODE, 32'h0000_0006);
    chk({31'h0, moff}, 32'h0, "medium not released");
    $display("test regs done");
  endtask
  task automatic t_frames;
    run(64, 2, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h1, "short preamble frame");
    chk({24'h0, first_b}, 32'h0, "first byte");
    chk(st & 32'h47FF_09D7, 32'h0040_0000, "good status");
    run(64, 16, 4'h0, 32'h0);
    chk(32'(ndone - base), 32'h0, "zero preamble aborts");
    mcast = 1'b1;
    run(70, 16, 4'h5, 32'h1);
    chk(st & 32'h4000_0DD7, 32'h0000_0402, "bad fcs multicast");
    mcast = 1'b0;
    $display("test frames done");
  endtask
  task automatic t_runt_filter;
    run(63, 16, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h0, "runt rejected");
    chk(st & 32'h800, 32'h800, "runt flag");
    wr(emrx_pkg::OFS_OPMODE, 32'h0000_0026);
    run(63, 16, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h1, "runt accepted");
    wr(emrx_pkg::OFS_OPMODE, 32'h0000_0006);
    @(posedge clk);
    match <= 1'b0;
    run(64, 16, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h0, "mismatch dropped");
    wr(emrx_pkg::OFS_OPMODE, 32'h4000_0006);
    run(64, 16, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h1, "accept all");
    chk(st & 32'h4000_0000, 32'h4000_0000, "filter fail flag");
    match <= 1'b1;
    wr(emrx_pkg::OFS_OPMODE, 32'h0000_0016);
    run(64, 4, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h0, "snooze 16 bits");
    run(64, 5, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h1, "snooze 20 bits");
    wr(emrx_pkg::OFS_OPMODE, 32'h0000_0006);
    $display("test runt filter done");
  endtask
  task automatic t_errors;
    emrx_phy_model_inst.drib = 1;
    run(64, 16, 4'h5, 32'h0);
    chk(st & 32'h4000_09D7, 32'h4, "dribble only");
    run(64, 16, 4'h5, 32'h1);
    chk(st & 32'h4000_09D7, 32'h106, "alignment");
    emrx_phy_model_inst.drib = 0;
    emrx_phy_model_inst.err_at = 60;
    run(64, 16, 4'h5, 32'h0);
    chk(st & 32'h2, 32'h2, "receive error");
    emrx_phy_model_inst.err_at = -1;
    emrx_phy_model_inst.coll_at = 140;
    run(80, 16, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h1, "late collision completes");
    chk(st & 32'h40, 32'h40, "collision seen");
    emrx_phy_model_inst.coll_at = -1;
    @(posedge clk);
    fifo_rdy <= 1'b0;
    run(64, 16, 4'h5, 32'h0);
    chk(st & 32'h1, 32'h1, "overflow");
    fifo_rdy <= 1'b1;
    run(1100, 16, 4'h5, 32'h0);
    chk(st & 32'h10, 32'h10, "watchdog status");
    rd(emrx_pkg::OFS_INTSTAT, d);
    chk(d & 32'h200, 32'h200, "watchdog interrupt status");
    wr(emrx_pkg::OFS_INTSTAT, 32'h200);
    rd(emrx_pkg::OFS_INTSTAT, d);
    chk(d & 32'h200, 32'h0, "watchdog cleared");
    $display("test errors done");
  endtask
  task automatic t_loop;
    wr(emrx_pkg::OFS_OPMODE, 32'h0000_0406);
    run(64, 16, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h0, "medium ignored in internal loop");
    use_loop <= 1'b1;
    run(64, 16, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h1, "internal loop frame");
    wr(emrx_pkg::OFS_OPMODE, 32'h0000_0806);
    use_loop <= 1'b0;
    run(64, 16, 4'h5, 32'h0);
    chk(32'(ndone - base), 32'h1, "external loop frame");
    $display("test loop done");
  endtask
  // ==========================================================================
  // sequence, watchdog and verdict
  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_frames;
    t_runt_filter;
    t_errors;
    t_loop;
    finish_test;
  end
  initial begin
    #9_000_000;
    failures++;
    $display("ERROR %0t: run did not complete", $time);
    finish_test;
  end
endmodule
